/* File: include/crds_regs.vh */
// Purpose: Constants for the configuration RAM and driver datagram sequencer.
// Assumes: 32-bit classic Wishbone, byte addresses, 20 MHz clock.
// Notes:   Definitions only.
`ifndef CRDS_REGS_VH
`define CRDS_REGS_VH

// Register byte offsets
`define CRDS_OFS_DGRAM   8'h00
`define CRDS_OFS_CTRL    8'h04
`define CRDS_OFS_TOL     8'h08
`define CRDS_OFS_LATCH   8'h0C
`define CRDS_OFS_STATUS  8'h10

// Register index carried in a register-space datagram
`define CRDS_IDX_CTRL    4'h1
`define CRDS_IDX_TOL     4'h2
`define CRDS_IDX_LATCH   4'h3
`define CRDS_IDX_STATUS  4'h4

// Host datagram fields
`define CRDS_DG_RRS      31
`define CRDS_DG_HALF     30
`define CRDS_DG_ADR_HI   30
`define CRDS_DG_ADR_LO   25
`define CRDS_DG_RW       24

// Control register fields
`define CRDS_CTRL_LAST_HI  1
`define CRDS_CTRL_LAST_LO  0
`define CRDS_CTRL_STOP_EN  2
`define CRDS_CTRL_START    3

// Configuration word fields
`define CRDS_W_FLAG      5

// Sizes and reset values
`define CRDS_CELLS       128
`define CRDS_SIG_PER_MOT 20
`define CRDS_LAST_WORD   6'h3F
`define CRDS_TBL_BASE    7'h40
`define CRDS_CTRL_RST    4'h0
`define CRDS_TOL_RST     24'h000000

// Driver link half-period in clocks minus one
`define CRDS_SCK_DIV     8'h0F

`endif

/* File: design/crds_wave.v */
// Purpose: Maps a microstep phase onto quarter-table index and polarity, both coils.
// Assumes: 256 phase steps per electrical period, 64 table entries per quarter.
// Notes:   Purely combinational; coil B leads coil A by a quarter period.
`timescale 1ns/100ps
module crds_wave (
	// Phase of one motor
	input  wire [7:0] phase_i,
	// Table index and polarity per coil
	output wire [5:0] idx_a_o,
	output wire       neg_a_o,
	output wire [5:0] idx_b_o,
	output wire       neg_b_o
);
	wire [7:0] phase_b;

	assign phase_b = phase_i + 8'h40;

	assign idx_a_o = phase_i[6] ? ~phase_i[5:0] : phase_i[5:0];
	assign idx_b_o = phase_b[6] ? ~phase_b[5:0] : phase_b[5:0];
	assign neg_a_o = phase_i[7];
	assign neg_b_o = phase_b[7];
endmodule // crds_wave

/* File: design/crds_top.v */
// Purpose: Configuration RAM, host datagram access, driver chain sequencing, reference latch and stop.
// Assumes: Classic Wishbone slave; ref_i is an asynchronous pin; pos_i and motion inputs share clk_i.
// Notes:   Config writes during a chain transmission are held and applied once it ends.
//
// Implementation choices: the placing of the registers and the Wishbone interface to the registers.
`timescale 1ns/100ps
`include "crds_regs.vh"

// Behaviour
// - 128 cells of 6 bits, 64 pairs
// - datagram data 24 bits, 12 used
// - datagram bit 31 picks registers or RAM
// - bit 30 splits RAM into halves
// - lower half holds flag plus code words
// - fetch words in order from address zero
// - code selects one signal of current motor
// - set flag increments driver counter
// - flag at last driver ends, counter cleared
// - upper half holds quarter wave table
// - one table shared by all motors
// - expand quarter to full and shifted wave
// - tolerance window suppresses automatic switch stop
// - write to latch register re-arms latch
// - switch edge captures position when armed
// - stop enabled halts motor at switch
// - transmission starts driver zero, word zero
// - snapshot primary signals before sending
module crds_top (
	// Clock and reset
	input  wire        clk_i,
	input  wire        rst_i,
	// Wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [7:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output reg  [31:0] wb_dat_o,
	output reg         wb_ack_o,
	// Microstep unit signals, three motors
	input  wire [23:0] phase_i,
	input  wire [2:0]  fd_a_i,
	input  wire [2:0]  fd_b_i,
	input  wire [2:0]  dir_i,
	input  wire [2:0]  step_i,
	input  wire        tx_req_i,
	// Reference switch and position of the searched axis
	input  wire        ref_i,
	input  wire [23:0] pos_i,
	output reg         stop_o,
	// Driver chain link
	output reg         sck_o,
	output reg         sdo_o,
	output reg         cs_n_o,
	output reg         busy_o
);
	localparam ST_IDLE = 3'd0;
	localparam ST_CSLO = 3'd1;
	localparam ST_BLO  = 3'd2;
	localparam ST_BHI  = 3'd3;
	localparam ST_DONE = 3'd4;

	reg [5:0] ram_q [0:`CRDS_CELLS-1];

	reg [3:0]  ctrl_q;
	reg [23:0] tol_q;
	reg [23:0] latch_q;
	reg        armed_q;
	reg        valid_q;
	reg [31:0] reply_q;
	reg        pend_q;
	reg [5:0]  pend_adr_q;
	reg [11:0] pend_dat_q;
	reg        start_pend_q;
	reg [2:0]  st_q;
	reg [7:0]  div_q;
	reg [5:0]  ptr_q;
	reg [1:0]  mot_q;
	reg [59:0] snap_q;
	reg        ref_m_q;
	reg        ref_s_q;
	reg        ref_d_q;
	reg [59:0] snap_d;
	integer    m;

	wire [5:0]  idx_a [0:2];
	wire [5:0]  idx_b [0:2];
	wire [2:0]  neg_a;
	wire [2:0]  neg_b;

	wire        req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire        is_dg   = (wb_adr_i == `CRDS_OFS_DGRAM);
	wire        stall   = is_dg & pend_q;
	wire        take    = req & ~stall;
	wire        wr      = take & wb_we_i & (wb_sel_i == 4'hF);
	wire        dg_go   = wr & is_dg;
	wire        dg_ram  = wb_dat_i[`CRDS_DG_RRS];
	wire        dg_rd   = wb_dat_i[`CRDS_DG_RW];
	wire [5:0]  dg_adr  = wb_dat_i[`CRDS_DG_ADR_HI:`CRDS_DG_ADR_LO];
	wire [3:0]  dg_idx  = wb_dat_i[`CRDS_DG_ADR_LO+3:`CRDS_DG_ADR_LO];
	wire        dg_regw = dg_go & ~dg_ram & ~dg_rd;
	wire        busy    = (st_q != ST_IDLE);
	wire        tick    = (div_q == 8'h00);
	wire [5:0]  word_c  = ram_q[{1'b0, ptr_q}];
	wire        flag    = word_c[`CRDS_W_FLAG];
	wire        edge_ev = ref_s_q ^ ref_d_q;
	wire [1:0]  last    = ctrl_q[`CRDS_CTRL_LAST_HI:`CRDS_CTRL_LAST_LO];

	wire wr_ctrl  = (wr & (wb_adr_i == `CRDS_OFS_CTRL))  | (dg_regw & (dg_idx == `CRDS_IDX_CTRL));
	wire wr_tol   = (wr & (wb_adr_i == `CRDS_OFS_TOL))   | (dg_regw & (dg_idx == `CRDS_IDX_TOL));
	wire wr_latch = (wr & (wb_adr_i == `CRDS_OFS_LATCH)) | (dg_regw & (dg_idx == `CRDS_IDX_LATCH));
	wire [31:0] wr_val = is_dg ? {8'h00, wb_dat_i[23:0]} : wb_dat_i;

	function sel_bit;
		input [59:0] sig;
		input [4:0]  code;
		input [1:0]  mot;
		begin
			if (code < 5'd20 && mot != 2'd3)
				sel_bit = sig[mot * `CRDS_SIG_PER_MOT + code];
			else
				sel_bit = 1'b0;
		end
	endfunction

	function [23:0] abs24;
		input [23:0] v;
		begin
			abs24 = v[23] ? (~v + 24'h000001) : v;
		end
	endfunction

	function [31:0] reg_rd;
		input [3:0] idx;
		begin
			case (idx)
				`CRDS_IDX_CTRL:   reg_rd = {29'h0, ctrl_q[2:0]};
				`CRDS_IDX_TOL:    reg_rd = {8'h00, tol_q};
				`CRDS_IDX_LATCH:  reg_rd = {8'h00, latch_q};
				`CRDS_IDX_STATUS: reg_rd = {26'h0, pend_q, stop_o, ref_s_q, valid_q, armed_q, busy};
				default:          reg_rd = 32'h00000000;
			endcase
		end
	endfunction

	genvar g;
	generate
		for (g = 0; g < 3; g = g + 1) begin : g_wave
			crds_wave u_wave (
				.phase_i (phase_i[g*8+7:g*8]),
				.idx_a_o (idx_a[g]),
				.neg_a_o (neg_a[g]),
				.idx_b_o (idx_b[g]),
				.neg_b_o (neg_b[g])
			);
		end
	endgenerate

	// upper half table into the signal set
	always @* begin
		snap_d = 60'h0;
		for (m = 0; m < 3; m = m + 1) begin
			snap_d[m*20 +: 6]  = ram_q[`CRDS_TBL_BASE + {1'b0, idx_a[m]}];
			snap_d[m*20 + 6]   = neg_a[m];
			snap_d[m*20 + 7]   = fd_a_i[m];
			snap_d[m*20 + 8 +: 6] = ram_q[`CRDS_TBL_BASE + {1'b0, idx_b[m]}];
			snap_d[m*20 + 14]  = neg_b[m];
			snap_d[m*20 + 15]  = fd_b_i[m];
			snap_d[m*20 + 16]  = 1'b0;
			snap_d[m*20 + 17]  = 1'b1;
			snap_d[m*20 + 18]  = dir_i[m];
			snap_d[m*20 + 19]  = step_i[m];
		end
	end

	// Bus answer and datagram execution
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o   <= 1'b0;
			wb_dat_o   <= 32'h00000000;
			reply_q    <= 32'h00000000;
			ctrl_q     <= `CRDS_CTRL_RST;
			tol_q      <= `CRDS_TOL_RST;
			pend_q     <= 1'b0;
			pend_adr_q <= 6'h00;
			pend_dat_q <= 12'h000;
		end else begin
			wb_ack_o <= take;
			if (take & ~wb_we_i) begin
				if (is_dg)
					wb_dat_o <= reply_q;
				else if (wb_adr_i[7:6] == 2'b00 && wb_adr_i[1:0] == 2'b00)
					wb_dat_o <= reg_rd(wb_adr_i[5:2]);
				else
					wb_dat_o <= 32'h00000000;
			end
			if (wr_ctrl)
				ctrl_q <= {1'b0, wr_val[2:0]};
			if (wr_tol)
				tol_q <= wr_val[23:0];
			if (dg_go) begin
				if (!dg_ram)
					reply_q <= dg_rd ? reg_rd(dg_idx) : 32'h00000000;
				else if (dg_rd)
					// two words in low twelve bits
					reply_q <= {20'h00000, ram_q[{dg_adr, 1'b1}], ram_q[{dg_adr, 1'b0}]};
				else
					reply_q <= 32'h00000000;
			end
			if (dg_go & dg_ram & ~dg_rd & ~wb_dat_i[`CRDS_DG_HALF] & busy) begin
				pend_q     <= 1'b1;
				pend_adr_q <= dg_adr;
				pend_dat_q <= wb_dat_i[11:0];
			end else if (pend_q & ~busy) begin
				pend_q <= 1'b0;
			end
		end
	end

	// RAM writes: immediate, or deferred for the config half
	always @(posedge clk_i) begin
		if (dg_go & dg_ram & ~dg_rd & ~(~wb_dat_i[`CRDS_DG_HALF] & busy)) begin
			ram_q[{dg_adr, 1'b0}] <= wb_dat_i[5:0];
			ram_q[{dg_adr, 1'b1}] <= wb_dat_i[11:6];
		end else if (pend_q & ~busy) begin
			ram_q[{pend_adr_q, 1'b0}] <= pend_dat_q[5:0];
			ram_q[{pend_adr_q, 1'b1}] <= pend_dat_q[11:6];
		end
	end

	// Reference switch, latch and stop
	always @(posedge clk_i) begin
		if (rst_i) begin
			ref_m_q <= 1'b0;
			ref_s_q <= 1'b0;
			ref_d_q <= 1'b0;
			armed_q <= 1'b0;
			valid_q <= 1'b0;
			latch_q <= 24'h000000;
			stop_o  <= 1'b0;
		end else begin
			ref_m_q <= ref_i;
			ref_s_q <= ref_m_q;
			ref_d_q <= ref_s_q;
			// capture wins over a same-cycle re-arm
			if (edge_ev & armed_q) begin
				latch_q <= pos_i;
				armed_q <= 1'b0;
				valid_q <= 1'b1;
			end else if (wr_latch) begin
				armed_q <= 1'b1;
				valid_q <= 1'b0;
			end
			stop_o <= ctrl_q[`CRDS_CTRL_STOP_EN] & ref_s_q &
			          ~((tol_q != 24'h000000) & valid_q & (abs24(pos_i - latch_q) <= tol_q));
		end
	end

	// Driver chain sequencer
	always @(posedge clk_i) begin
		if (rst_i) begin
			st_q         <= ST_IDLE;
			div_q        <= `CRDS_SCK_DIV;
			ptr_q        <= 6'h00;
			mot_q        <= 2'b00;
			snap_q       <= 60'h0;
			start_pend_q <= 1'b0;
			sck_o        <= 1'b0;
			sdo_o        <= 1'b0;
			cs_n_o       <= 1'b1;
			busy_o       <= 1'b0;
		end else begin
			div_q  <= (tick | ~busy) ? `CRDS_SCK_DIV : div_q - 8'h01;
			busy_o <= busy ? ~((st_q == ST_DONE) & tick) : (start_pend_q & ~pend_q);
			if (tx_req_i | (wr_ctrl & wr_val[`CRDS_CTRL_START]))
				start_pend_q <= 1'b1;
			else if (st_q == ST_IDLE && !pend_q)
				start_pend_q <= 1'b0;
			case (st_q)
				ST_IDLE: begin
					if (start_pend_q & ~pend_q) begin
						snap_q <= snap_d;
						// begin at driver zero, word zero
						ptr_q  <= 6'h00;
						mot_q  <= 2'b00;
						cs_n_o <= 1'b0;
						st_q   <= ST_CSLO;
					end
				end
				ST_CSLO: begin
					if (tick)
						st_q <= ST_BLO;
				end
				ST_BLO: begin
					sck_o <= 1'b0;
					// code picks one bit of current motor
					sdo_o <= sel_bit(snap_q, word_c[4:0], mot_q);
					if (tick)
						st_q <= ST_BHI;
				end
				ST_BHI: begin
					sck_o <= 1'b1;
					if (tick) begin
						if (flag && mot_q == last) begin
							mot_q <= 2'b00;
							st_q  <= ST_DONE;
						end else if (ptr_q == `CRDS_LAST_WORD) begin
							st_q <= ST_DONE;
						end else begin
							if (flag)
								mot_q <= mot_q + 2'b01;
							ptr_q <= ptr_q + 6'h01;
							st_q  <= ST_BLO;
						end
					end
				end
				ST_DONE: begin
					sck_o  <= 1'b0;
					cs_n_o <= 1'b1;
					if (tick)
						st_q <= ST_IDLE;
				end
				default: st_q <= ST_IDLE;
			endcase
		end
	end
endmodule // crds_top

/* File: verif/crds_top_sva.sv */
// Purpose: Bus and chain link checks for crds_top.
// Assumes: Top ports only, one clock domain.
// Notes:   Offset 0x00 may stall, so its ack latency is left open.
`timescale 1ns/100ps
module crds_top_sva (
	// Clock, reset and bus
	input wire logic       clk_i,
	input wire logic       rst_i,
	input wire logic       wb_cyc_i,
	input wire logic       wb_stb_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic       wb_ack_o,
	// Switch and link
	input wire logic       ref_i,
	input wire logic       stop_o,
	input wire logic       sck_o,
	input wire logic       sdo_o,
	input wire logic       cs_n_o,
	input wire logic       busy_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_high;
		$rose(sck_o) ##16 $fell(sck_o);
	endsequence
	AST_ACK_NEXT: assert property (s_req ##0 (wb_adr_i != 8'h00) |=> wb_ack_o)
		else $error("ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	AST_ACK_CAUSE: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	AST_CS_IDLE: assert property (!busy_o |-> cs_n_o)
		else $error("select while idle");
	AST_SCK_IDLE: assert property (cs_n_o |-> !sck_o)
		else $error("clock outside frame");
	AST_SDO_STABLE: assert property ($rose(sck_o) |-> $stable(sdo_o))
		else $error("data moved at rise");
	AST_HALF_BIT: assert property ($rose(sck_o) |-> s_high)
		else $error("half bit length");
	AST_STOP_CAUSE: assert property ($rose(stop_o) |-> $past(ref_i, 3))
		else $error("stop without switch");
	AST_RESET_VAL: assert property ($fell(rst_i) |-> cs_n_o && !busy_o && !wb_ack_o && !stop_o)
		else $error("reset values");
endmodule // crds_top_sva

bind crds_top crds_top_sva chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
	.wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o), .ref_i(ref_i), .stop_o(stop_o), .sck_o(sck_o),
	.sdo_o(sdo_o), .cs_n_o(cs_n_o), .busy_o(busy_o));

/* File: verif/crds_chain_model.sv */
// Purpose: Receiving end of the driver chain, collects one frame.
// Assumes: A bit is taken at each rising link clock while selected.
// Notes:   Keeps 16 bits; older ones fall off the top.
`timescale 1ns/100ps
module crds_chain_model (
	// Clock and link
	input  wire logic        clk_i,
	input  wire logic        sck_i,
	input  wire logic        sdo_i,
	input  wire logic        cs_n_i,
	// Captured frame
	output logic      [4:0]  cnt_o,
	output logic      [15:0] bits_o
);
	logic sck_q;
	logic cs_n_q;
	always @(posedge clk_i) begin
		sck_q <= sck_i;
		cs_n_q <= cs_n_i;
		if (cs_n_q && !cs_n_i) begin
			cnt_o <= 5'h00;
			bits_o <= 16'h0000;
		end
		else if (!cs_n_i && sck_i && !sck_q) begin
			cnt_o <= cnt_o + 5'h01;
			bits_o <= {bits_o[14:0], sdo_i};
		end
	end
endmodule // crds_chain_model

/* File: verif/tb_config_ram_datagram_sequencer.sv */
// Purpose: Self-checking bench for crds_top.
// Assumes: Bench acts as Wishbone host; chain model on the link.
// Notes:   Fixed waits cover the switch synchroniser and the registered stop output.
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin errors++; \
	$display("CHECK FAILED %s exp %0h got %0h", nm, e, g); end end
module tb_config_ram_datagram_sequencer;
	logic        clk_i, rst_i, cyc, stb, we, ref_i, tx_req;
	logic [7:0]  adr;
	logic [3:0]  sel;
	logic [2:0]  dir;
	logic [31:0] dat, rd;
	logic [23:0] pos, phase;
	wire  [31:0] wb_dat_o;
	wire         wb_ack_o, stop_o, sck_o, sdo_o, cs_n_o, busy_o;
	wire  [4:0]  cnt;
	wire  [15:0] bits;
	int          errors, compares;
	crds_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.phase_i(phase), .fd_a_i(3'h0), .fd_b_i(3'h0), .dir_i(dir), .step_i(3'h0),
		.tx_req_i(tx_req), .ref_i(ref_i), .pos_i(pos), .stop_o(stop_o), .sck_o(sck_o),
		.sdo_o(sdo_o), .cs_n_o(cs_n_o), .busy_o(busy_o));
	crds_chain_model chain (.clk_i(clk_i), .sck_i(sck_o), .sdo_i(sdo_o), .cs_n_i(cs_n_o),
		.cnt_o(cnt), .bits_o(bits));
	task complete_run;
		if (errors == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		dat <= d;
		do begin
			@(posedge clk_i);
		end while (wb_ack_o !== 1'b1);
		rd = wb_dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	// Upper data bits are junk and must be dropped
	task ram_wr(input logic [5:0] a, input logic [11:0] v);
		wb(1'b1, 8'h00, {1'b1, a, 1'b0, 12'hABC, v});
	endtask
	task chain_wait(input logic [4:0] n, input logic [15:0] b);
		while (busy_o !== 1'b1) begin
			@(posedge clk_i);
		end
		while (busy_o !== 1'b0) begin
			@(posedge clk_i);
		end
		`CHK("bit count", n, cnt)
		`CHK("bit values", b, bits)
	endtask
	task t_ram;
		logic [5:0] a;
		for (int i = 0; i < 4; i++) begin
			a = {i[1], {5{i[0]}}};
			ram_wr(a, {a, ~a});
		end
		for (int i = 0; i < 4; i++) begin
			a = {i[1], {5{i[0]}}};
			wb(1'b1, 8'h00, {1'b1, a, 1'b1, 24'h000000});
			wb(1'b0, 8'h00, 32'h0);
			`CHK("ram word", {20'h0, a, ~a}, rd)
		end
		wb(1'b0, 8'h40, 32'h0);
		`CHK("unmapped", 32'h0, rd)
	endtask
	task t_chain;
		ram_wr(6'h00, {6'h30, 6'h11});
		ram_wr(6'h01, {6'h00, 6'h32});
		wb(1'b1, 8'h04, 32'h9);
		dir <= 3'b000; // sent bit must come from the snapshot
		chain_wait(5'd3, 16'h0005);
		wb(1'b1, 8'h04, 32'h8);
		ram_wr(6'h00, 12'h031);
		chain_wait(5'd2, 16'h0002);
		wb(1'b1, 8'h04, 32'h8);
		chain_wait(5'd1, 16'h0001);
	endtask
	// Motor 0 in a mirrored quarter, motor 1 at phase zero
	task t_wave;
		phase <= 24'h0000C1;
		ram_wr(6'h00, {6'h06, 6'h05});
		ram_wr(6'h01, {6'h28, 6'h0D});
		ram_wr(6'h02, {6'h00, 6'h20});
		wb(1'b1, 8'h00, 32'h02000001);
		wb(1'b1, 8'h00, 32'h03000000);
		wb(1'b0, 8'h00, 32'h0);
		`CHK("dgram ctrl", 32'h1, rd)
		wb(1'b0, 8'h44, 32'h0);
		`CHK("alias", 32'h0, rd)
		tx_req <= 1'b1;
		@(posedge clk_i);
		tx_req <= 1'b0;
		chain_wait(5'd5, 16'h000D);
	endtask
	task t_latch;
		wb(1'b1, 8'h0C, 32'h0);
		wb(1'b1, 8'h04, 32'h4);
		ref_i <= 1'b1;
		repeat (8) @(posedge clk_i);
		`CHK("stop", 1'b1, stop_o)
		sel <= 4'h1;
		wb(1'b1, 8'h08, 32'h10);
		sel <= 4'hF;
		repeat (4) @(posedge clk_i);
		`CHK("stop kept", 1'b1, stop_o)
		wb(1'b1, 8'h08, 32'h10);
		repeat (4) @(posedge clk_i);
		`CHK("stop in window", 1'b0, stop_o)
		pos <= 24'h000200;
		repeat (4) @(posedge clk_i);
		`CHK("stop outside", 1'b1, stop_o)
		wb(1'b0, 8'h10, 32'h0);
		`CHK("status", 32'h1C, rd)
		wb(1'b0, 8'h0C, 32'h0);
		`CHK("latched", 32'h100, rd)
		wb(1'b1, 8'h0C, 32'h0);
		ref_i <= 1'b0;
		repeat (8) @(posedge clk_i);
		wb(1'b0, 8'h0C, 32'h0);
		`CHK("relatched", 32'h200, rd)
	endtask
	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end
	initial begin
		repeat (20000) @(posedge clk_i);
		errors++;
		complete_run;
	end
	initial begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		dat = 32'h0;
		sel = 4'hF;
		dir = 3'b010;
		ref_i = 1'b0;
		pos = 24'h000100;
		phase = 24'h000000;
		tx_req = 1'b0;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		`CHK("reset", 4'h8, {cs_n_o, busy_o, wb_ack_o, stop_o})
		t_ram;
		t_chain;
		t_wave;
		t_latch;
		complete_run;
	end
endmodule // tb_config_ram_datagram_sequencer
